// File: design/sadc_map.svh
// timing and frame constants for the converter serial port
// What this block does
// - strobe fall puts track/hold into hold
// - strobe fall drives serial output low
// - serial clock steps approximation, bits shift out
// - output level changes only after serial-clock rising edges or a strobe fall; the drive is also released at a strobe rise
// - MSB appears after the 4th rising edge
// - track/hold resumes tracking at 14th rise
// - track/hold tracks immediately after power-up
// - strobe low at 16th fall releases output at the next clock rise or strobe rise
// - frame: three zeros, twelve bits, one zero
// - unipolar straight binary, bipolar two's complement
`ifndef SADC_MAP_SVH
`define SADC_MAP_SVH
`define SADC_BITS        12
`define SADC_PTR_W       4
`define SADC_CNT_W       5
`define SADC_LEAD_ZEROS  5'h03
`define SADC_MSB_EDGE    5'h04
`define SADC_LSB_EDGE    5'h0F
`define SADC_TRACK_EDGE  5'h0E
`define SADC_LAST_EDGE   5'h10
`define SADC_CLK_NS      50
`define SADC_ACQ_NS      125
`define SADC_ACQ_CYC     ((`SADC_ACQ_NS + `SADC_CLK_NS - 1) / `SADC_CLK_NS)
`define SADC_ACQ_W       8
`endif

// File: design/sadc_pkg.sv
// types shared by the converter serial port
package sadc_pkg;
  typedef enum logic [1:0] {
    SADC_IDLE,
    SADC_CONV,
    SADC_DONE
  } sadc_state_type;
endpackage

// File: design/sadc_sar.sv
// successive-approximation register: trial code and bit decisions
`timescale 1ns/1ns
`include "sadc_map.svh"
module sadc_sar (
  input  wire logic                  core_clk,  // system clock
  input  wire logic                  srst,      // sync reset, high
  input  wire logic                  start,     // begin a new approximation
  input  wire logic                  step,      // decide current bit
  input  wire logic                  comp_high, // input above trial level
  output logic [`SADC_BITS-1:0]      dac_code   // trial code to the dac
);
  logic [`SADC_BITS-1:0]  code;
  logic [`SADC_PTR_W-1:0] ptr;
  logic [`SADC_BITS-1:0]  next_code;
  logic [`SADC_PTR_W-1:0] next_ptr;

  always_comb begin
    next_code = code;
    next_ptr  = ptr;
    if (start) begin
      next_code = {1'b1, {(`SADC_BITS-1){1'b0}}};
      next_ptr  = `SADC_PTR_W'(`SADC_BITS - 1);
    end else if (step) begin
      next_code[ptr] = comp_high;
      if (ptr != '0) begin
        next_code[ptr - `SADC_PTR_W'(1)] = 1'b1;
        next_ptr = ptr - `SADC_PTR_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      code <= '0;
      ptr  <= '0;
    end else begin
      code <= next_code;
      ptr  <= next_ptr;
    end
  end

  assign dac_code = code;
endmodule

// File: design/sadc_port.sv
// conversion sequencing and serial readout of the 12-bit converter
`timescale 1ns/1ns
`include "sadc_map.svh"
module sadc_port #(
  parameter bit BIPOLAR = 1'b0 // 1: two's complement result
) (
  input  wire logic                 core_clk,             // 20 MHz clock
  input  wire logic                 srst,                 // sync reset, high
  input  wire logic                 serial_clk,           // host serial clock
  input  wire logic                 convert_start_strobe, // host strobe
  input  wire logic                 comp_high,            // comparator out
  output logic                      serial_data_out,      // data to host
  output logic                      serial_data_oe,       // high: drive line
  output logic                      track_hold_hold,      // high: hold mode
  output logic [`SADC_BITS-1:0]     dac_code,             // sar trial code
  output logic                      calibrated,           // first cycle done
  output logic                      acq_short             // last start early
);
  // pin synchronisers; stage one feeds only stage two
  logic [1:0] sclk_sync;
  logic [1:0] strb_sync;
  logic [1:0] comp_sync;
  logic       sclk_prev;
  logic       strb_prev;
  logic [1:0] next_sclk_sync;
  logic [1:0] next_strb_sync;
  logic [1:0] next_comp_sync;

  always_comb begin
    next_sclk_sync = {sclk_sync[0], serial_clk};
    next_strb_sync = {strb_sync[0], convert_start_strobe};
    next_comp_sync = {comp_sync[0], comp_high};
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      sclk_sync <= 2'h0;
      strb_sync <= 2'h3;
      comp_sync <= 2'h0;
      sclk_prev <= 1'b0;
      strb_prev <= 1'b1;
    end else begin
      sclk_sync <= next_sclk_sync;
      strb_sync <= next_strb_sync;
      comp_sync <= next_comp_sync;
      sclk_prev <= sclk_sync[1];
      strb_prev <= strb_sync[1];
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic strb_fall;
  logic strb_rise;
  logic strb_lvl;
  logic comp_bit;
  assign sclk_rise = sclk_sync[1] & ~sclk_prev;
  assign sclk_fall = ~sclk_sync[1] & sclk_prev;
  assign strb_fall = ~strb_sync[1] & strb_prev;
  assign strb_rise = strb_sync[1] & ~strb_prev;
  assign strb_lvl  = strb_sync[1];
  assign comp_bit  = comp_sync[1];

  // sequencing state
  sadc_pkg::sadc_state_type     state;
  sadc_pkg::sadc_state_type     next_state;
  logic [`SADC_CNT_W-1:0]       count;
  logic [`SADC_CNT_W-1:0]       next_count;
  logic [`SADC_CNT_W-1:0]       edge_num;
  logic                         release_pend;
  logic                         next_release_pend;
  logic                         next_dout;
  logic                         next_oe;
  logic                         next_hold;
  logic                         next_cal;
  logic [`SADC_ACQ_W-1:0]       acq_cnt;
  logic [`SADC_ACQ_W-1:0]       next_acq_cnt;
  logic                         next_acq_short;
  logic                         sar_step;

  assign edge_num = count + `SADC_CNT_W'(1);
  assign sar_step = (state == sadc_pkg::SADC_CONV) && sclk_rise && !strb_fall
                    && edge_num >= `SADC_MSB_EDGE
                    && edge_num <= `SADC_LSB_EDGE;

  always_comb begin
    next_state        = state;
    next_count        = count;
    next_release_pend = release_pend;
    next_dout         = serial_data_out;
    next_oe           = serial_data_oe;
    next_hold         = track_hold_hold;
    next_cal          = calibrated;
    next_acq_short    = acq_short;
    // acquisition time counted while tracking, saturating
    if (track_hold_hold)
      next_acq_cnt = '0;
    else if (acq_cnt != '1)
      next_acq_cnt = acq_cnt + `SADC_ACQ_W'(1);
    else
      next_acq_cnt = acq_cnt;
    if (strb_fall) begin
      // a new start always wins over anything still pending
      next_state        = sadc_pkg::SADC_CONV;
      next_count        = '0;
      next_hold         = 1'b1;
      next_dout         = 1'b0;
      next_oe           = 1'b1;
      next_release_pend = 1'b0;
      next_acq_short    = acq_cnt < `SADC_ACQ_W'(`SADC_ACQ_CYC);
    end else begin
      if (release_pend && (sclk_rise || strb_rise)) begin
        next_oe           = 1'b0;
        next_dout         = 1'b0;
        next_release_pend = 1'b0;
      end
      case (state)
        sadc_pkg::SADC_CONV: begin
          if (sclk_rise) begin
            next_count = edge_num;
            if (edge_num <= `SADC_LEAD_ZEROS)
              next_dout = 1'b0;
            else if (edge_num == `SADC_MSB_EDGE)
              next_dout = comp_bit ^ BIPOLAR;
            else if (edge_num <= `SADC_LSB_EDGE)
              next_dout = comp_bit;
            else begin
              next_dout  = 1'b0;
              next_state = sadc_pkg::SADC_DONE;
              next_cal   = 1'b1;
            end
            if (edge_num == `SADC_TRACK_EDGE)
              next_hold = 1'b0;
          end
        end
        sadc_pkg::SADC_DONE: begin
          if (sclk_fall) begin
            next_state = sadc_pkg::SADC_IDLE;
            if (!strb_lvl)
              next_release_pend = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state           <= sadc_pkg::SADC_IDLE;
      count           <= '0;
      release_pend    <= 1'b0;
      serial_data_out <= 1'b0;
      serial_data_oe  <= 1'b0;
      track_hold_hold <= 1'b0;
      calibrated      <= 1'b0;
      acq_cnt         <= '0;
      acq_short       <= 1'b0;
    end else begin
      state           <= next_state;
      count           <= next_count;
      release_pend    <= next_release_pend;
      serial_data_out <= next_dout;
      serial_data_oe  <= next_oe;
      track_hold_hold <= next_hold;
      calibrated      <= next_cal;
      acq_cnt         <= next_acq_cnt;
      acq_short       <= next_acq_short;
    end
  end

  sadc_sar u_sar (
    .core_clk  (core_clk),
    .srst      (srst),
    .start     (strb_fall),
    .step      (sar_step),
    .comp_high (comp_bit),
    .dac_code  (dac_code)
  );

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  AST_HOLD_ON_START: assert property (
    strb_fall |=> track_hold_hold && serial_data_oe && !serial_data_out)
    else $error("strobe fall did not hold and drive low");
  AST_COUNT_CLEAR: assert property (
    strb_fall |=> count == '0 && state == sadc_pkg::SADC_CONV)
    else $error("edge count not cleared on strobe fall");
  AST_TRACK_AT_14: assert property (
    sclk_rise && !strb_fall && state == sadc_pkg::SADC_CONV
    && count == 5'h0D |=> !track_hold_hold)
    else $error("track/hold not tracking at 14th edge");
  AST_MSB_AT_4: assert property (
    sclk_rise && !strb_fall && state == sadc_pkg::SADC_CONV
    && count == 5'h03 |=> serial_data_out == ($past(comp_bit) ^ BIPOLAR))
    else $error("msb not presented after 4th edge");
  AST_ONLY_ON_RISE: assert property (
    !sclk_rise && !strb_fall |=> $stable(serial_data_out))
    else $error("serial output changed without rising edge");
  AST_LEAD_ZEROS: assert property (
    sclk_rise && !strb_fall && state == sadc_pkg::SADC_CONV
    && count < `SADC_LEAD_ZEROS |=> !serial_data_out)
    else $error("leading zero bit not low");
  AST_TRAIL_ZERO: assert property (
    sclk_rise && !strb_fall && state == sadc_pkg::SADC_CONV
    && count == 5'h0F |=> !serial_data_out && calibrated)
    else $error("trailing zero missing");
  AST_RELEASE: assert property (
    release_pend && !strb_fall && (sclk_rise || strb_rise)
    |=> !serial_data_oe)
    else $error("serial output not released");
  AST_KEEP_DRIVEN: assert property (
    state == sadc_pkg::SADC_DONE && sclk_fall && strb_lvl
    |=> serial_data_oe [*2])
    else $error("output dropped in continuous mode");
  AST_INIT_TRACK: assert property (
    $fell(srst) |-> !track_hold_hold && !serial_data_oe)
    else $error("not tracking after reset");
  AST_SAR_MSB: assert property (
    strb_fall |=> dac_code[`SADC_BITS-1])
    else $error("sar trial msb not set on start");

  COV_FULL_FRAME: cover property (
    state == sadc_pkg::SADC_CONV ##[1:1000] calibrated);
  COV_RELEASE: cover property (release_pend ##1 !serial_data_oe);
  COV_CONTINUOUS: cover property (
    state == sadc_pkg::SADC_DONE && sclk_fall && strb_lvl);
  COV_ACQ_SHORT: cover property ($rose(acq_short));
endmodule

// File: verif/sadc_host.sv
// host-side model: drives serial clock and start strobe, captures frames
`timescale 1ns/1ns
module sadc_host (
  input  wire logic core_clk,            // bench clock
  input  wire logic serial_data_out,     // converter data
  input  wire logic serial_data_oe,      // converter drive enable
  input  wire logic track_hold_hold,     // converter hold flag
  output logic      serial_clk,          // stands low between frames
  output logic      convert_start_strobe // idles high
);
  initial begin
    serial_clk = 1'b0;
    convert_start_strobe = 1'b1;
  end
  // half of the 400 ns serial period is four core_clk cycles
  task automatic half();
    repeat (4) @(negedge core_clk);
  endtask
  task automatic run(input int nrise, input bit cont,
                     output logic [15:0] data, oe_v, hold_v);
    data = 16'h0000;
    oe_v = 16'h0000;
    hold_v = 16'h0000;
    if (convert_start_strobe === 1'b0) begin
      convert_start_strobe = 1'b1;
      half();
    end
    half();
    convert_start_strobe = 1'b0;
    half();
    for (int k = 0; k < nrise; k++) begin
      if (cont && k == 14) convert_start_strobe = 1'b1;
      serial_clk = 1'b1;
      half();
      // sampled just before the fall: the bit is settled by then
      // an undriven line has no pull: read it as the inverse so a lost
      // drive cannot pass for a good bit
      data[15-k] = serial_data_oe ? serial_data_out : ~serial_data_out;
      oe_v[15-k] = serial_data_oe;
      hold_v[15-k] = track_hold_hold;
      serial_clk = 1'b0;
      half();
    end
  endtask
  // one lone edge outside a frame: clock rise or strobe rise
  task automatic kick(input bit use_clk);
    if (use_clk) serial_clk = 1'b1;
    else convert_start_strobe = 1'b1;
    half();
    serial_clk = 1'b0;
    half();
  endtask
endmodule

// File: verif/sadc_port_test.sv
// self-checking bench for the converter serial port
`timescale 1ns/1ns
`include "sadc_map.svh"
module sadc_port_test;
  logic                  core_clk = 1'b0;
  logic                  srst = 1'b1;
  logic                  comp_high = 1'b0;
  logic [11:0]           target = 12'h000;
  logic                  serial_clk;
  logic                  convert_start_strobe;
  logic                  serial_data_out;
  logic                  serial_data_oe;
  logic                  track_hold_hold;
  logic [`SADC_BITS-1:0] dac_code;
  logic                  calibrated;
  logic                  acq_short;
  int                    n_mismatch = 0;
  int                    checks = 0;

  always #25 core_clk = ~core_clk;
  // ideal comparator: input stands at the target code
  always @(negedge core_clk) comp_high <= (dac_code <= target);

  sadc_port #(.BIPOLAR(1'b0)) i_sadc_port (
    .core_clk(core_clk), .srst(srst), .serial_clk(serial_clk),
    .convert_start_strobe(convert_start_strobe), .comp_high(comp_high),
    .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe),
    .track_hold_hold(track_hold_hold), .dac_code(dac_code),
    .calibrated(calibrated), .acq_short(acq_short));
  sadc_host i_sadc_host (
    .core_clk(core_clk), .serial_data_out(serial_data_out),
    .serial_data_oe(serial_data_oe), .track_hold_hold(track_hold_hold),
    .serial_clk(serial_clk), .convert_start_strobe(convert_start_strobe));

  task automatic chk(input string what, input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic t_reset();
    chk("oe", 16'(serial_data_oe), 16'h0000);
    chk("hold", 16'(track_hold_hold), 16'h0000);
    chk("cal", 16'(calibrated), 16'h0000);
    chk("dac", 16'(dac_code), 16'h0000);
  endtask
  // early: the start came before SADC_ACQ_CYC cycles of tracking had passed
  task automatic t_frame(input logic [11:0] code, input bit cont,
                         input bit early);
    logic [15:0] d, o, h;
    target = code;
    i_sadc_host.run(16, cont, d, o, h);
    chk("frame", d, {3'b000, code, 1'b0});
    chk("drive", o, 16'hFFFF);
    chk("hold", h, 16'hFFF8);
    chk("oe_after_16", 16'(serial_data_oe), 16'h0001);
    chk("cal", 16'(calibrated), 16'h0001);
    chk("acq_short", 16'(acq_short), 16'(early));
  endtask
  // lone conversions at both ends of the code range, clock-rise release
  task automatic t_single(input logic [11:0] code);
    t_frame(code, 1'b0, 1'b0);
    i_sadc_host.kick(1'b1);
    chk("release_clk", 16'(serial_data_oe), 16'h0000);
    i_sadc_host.kick(1'b1);
    chk("idle_clk", 16'(serial_data_oe), 16'h0000);
  endtask
  // back-to-back frames, then strobe-rise release
  task automatic t_cont();
    t_frame(12'hA5C, 1'b1, 1'b0);
    t_frame(12'h5A3, 1'b0, 1'b0);
    i_sadc_host.kick(1'b0);
    chk("release_strobe", 16'(serial_data_oe), 16'h0000);
  endtask
  // a new start in mid-frame restarts the count
  task automatic t_abort();
    logic [15:0] d, o, h;
    target = 12'h3C7;
    i_sadc_host.run(6, 1'b0, d, o, h);
    chk("part", 16'(d[15:10]), 16'h0001);
    // the aborted frame never reached tracking, so the restart is early
    t_frame(12'h801, 1'b0, 1'b1);
  endtask

  initial begin
    repeat (12) @(negedge core_clk);
    srst = 1'b0;
    t_reset();
    t_single(12'h000);
    t_single(12'hFFF);
    t_cont();
    t_abort();
    give_verdict();
  end
  // about 800 cycles are needed; anything far beyond is a hang
  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    give_verdict();
  end
endmodule
